// ==== core/ccm_top.sv ====
// Capture/compare channel: output compare and PWM generation, or input capture into a FIFO.
// Assumes control inputs come from same-clock logic; the capture pin is asynchronous.
// Notes on behaviour
// - Compare timer against one or two values
// - Match gives event and edge or pulses
// - Modes 1/2/3: high, low, toggle; 16/32
// - Mode 4 dual edge; 5 buffered PWM
// - Mode 6 center-aligned pulse, buffered 16-bit
// - Mode 7 variable-frequency pulse, 16/32 bit
// - Capture own timer on pin or trigger
// - Capture timer counts up, 16/32 bit
// - Each capture pushes timer into FIFO; one taken while the holding slot and the FIFO are both full is lost
// - Timer readable through one synchronising stage
// - Select bit and mode field pick capture
// - Capture modes 0-3: edge, rise, fall, both
// - Mode 4 every 4th, 5 every 16th rise
module ccm_top #(
    parameter int FIFO_DEPTH = ccm_pkg::CCM_FIFO_DEPTH
) (
    input  wire logic                 clk_i,
    input  wire logic                 reset_i,
    input  wire logic                 enable_i,
    input  wire ccm_pkg::ccm_ctl_t    channel_control_low_i,
    input  wire logic [31:0]          compare_a_i,
    input  wire logic [31:0]          compare_b_i,
    input  wire logic [31:0]          period_i,
    input  wire logic                 capture_pin_i,
    input  wire logic                 trig_i,
    input  wire logic                 trig_select_i,
    input  wire logic                 overflow_clear_i,
    input  wire logic                 cap_ready_i,
    output logic                      cap_valid_o,
    output logic [31:0]               cap_data_o,
    output logic                      compare_out_o,
    output logic                      compare_event_o,
    output logic                      overflow_o,
    output logic [31:0]               channel_timer_value_o
);
    ccm_pkg::ccm_state_t st_r;
    ccm_pkg::ccm_state_t st_nxt;
    logic                fifo_ready;
    logic                wide;
    logic [3:0]          mode;
    logic [31:0]         msk;
    logic [31:0]         cmp_a;
    logic [31:0]         cmp_b;
    logic [31:0]         prd;
    logic                match_a;
    logic                match_b;
    logic                roll;
    logic [32:0]         acc_sum;
    logic                carry;
    logic                src;
    logic                src_prev;
    logic                rise;
    logic                fall;
    logic                cap_hit;
    logic                oc_legal;
    logic                uses_b;

    function automatic logic [31:0] ccm_fit(input logic [31:0] v, input logic w);
        ccm_fit = v & (w ? ccm_pkg::CCM_WIDE_MSK : ccm_pkg::CCM_NARROW_MSK);
    endfunction

    assign wide = channel_control_low_i.wide_count_select;
    assign mode = channel_control_low_i.mode;
    assign msk  = ccm_fit(ccm_pkg::CCM_WIDE_MSK, wide);
    assign prd  = ccm_fit(period_i, wide);
    assign roll = (st_r.oc_tmr == prd);

    // Dual edge, PWM and center modes exist only as 16-bit; wide forms do nothing
    always_comb begin
        oc_legal = 1'b0;
        case (mode)
            ccm_pkg::OC_HIGH, ccm_pkg::OC_LOW, ccm_pkg::OC_TOGGLE, ccm_pkg::OC_VARFREQ: oc_legal = 1'b1;
            ccm_pkg::OC_DUAL, ccm_pkg::OC_DUAL_BUF, ccm_pkg::OC_CENTER: oc_legal = ~wide;
            default: oc_legal = 1'b0;
        endcase
    end

    // Buffered modes use values latched at rollover so a period never sees a torn pair
    always_comb begin
        case (mode)
            ccm_pkg::OC_DUAL_BUF: begin
                cmp_a = st_r.buf_a;
                cmp_b = st_r.buf_b;
            end
            ccm_pkg::OC_CENTER: begin
                cmp_a = ccm_fit(st_r.buf_a - (st_r.buf_b >> 1), 1'b0);
                cmp_b = ccm_fit(st_r.buf_a + (st_r.buf_b >> 1), 1'b0);
            end
            default: begin
                cmp_a = ccm_fit(compare_a_i, wide);
                cmp_b = ccm_fit(compare_b_i, wide);
            end
        endcase
    end

    assign match_a = (st_r.fn == ccm_pkg::CCM_OC) && oc_legal && (st_r.oc_tmr == cmp_a);
    assign match_b = (st_r.fn == ccm_pkg::CCM_OC) && oc_legal && (st_r.oc_tmr == cmp_b);
    assign uses_b  = (mode == ccm_pkg::OC_DUAL) || (mode == ccm_pkg::OC_DUAL_BUF)
                     || (mode == ccm_pkg::OC_CENTER);

    // Variable frequency: phase accumulator, carry out of the selected width is the pulse
    assign acc_sum = {1'b0, st_r.acc} + {1'b0, ccm_fit(compare_a_i, wide)};
    assign carry   = wide ? acc_sum[32] : acc_sum[16];

    assign src      = trig_select_i ? trig_i : st_r.pin_sync[1];
    assign src_prev = trig_select_i ? st_r.trig_prev : st_r.pin_prev;
    assign rise     = src & ~src_prev;
    assign fall     = ~src & src_prev;

    always_comb begin
        cap_hit = 1'b0;
        case (mode)
            ccm_pkg::IC_EDGE, ccm_pkg::IC_BOTH: cap_hit = rise | fall;
            ccm_pkg::IC_RISE: cap_hit = rise;
            ccm_pkg::IC_FALL: cap_hit = fall;
            ccm_pkg::IC_RISE4: cap_hit = rise && (st_r.pre_cnt[1:0] == ccm_pkg::CCM_PRE_4TH[1:0]);
            ccm_pkg::IC_RISE16: cap_hit = rise && (st_r.pre_cnt == ccm_pkg::CCM_PRE_16TH);
            default: cap_hit = 1'b0;
        endcase
        if (st_r.fn != ccm_pkg::CCM_IC) begin
            cap_hit = 1'b0;
        end
    end

    always_comb begin
        st_nxt           = st_r;
        st_nxt.evt       = 1'b0;
        st_nxt.cap_push  = st_r.cap_push & ~fifo_ready;
        st_nxt.pin_sync  = {st_r.pin_sync[0], capture_pin_i};
        st_nxt.pin_prev  = st_r.pin_sync[1];
        st_nxt.trig_prev = trig_i;
        st_nxt.tmr_view  = st_r.ic_tmr;
        if (!enable_i) begin
            st_nxt.fn = ccm_pkg::CCM_OFF;
        end else if (channel_control_low_i.capture_function_select) begin
            st_nxt.fn = ccm_pkg::CCM_IC;
        end else begin
            st_nxt.fn = ccm_pkg::CCM_OC;
        end
        case (st_r.fn)
            ccm_pkg::CCM_OC: begin
                st_nxt.oc_tmr = roll ? ccm_pkg::CCM_TMR_RST : ccm_fit(st_r.oc_tmr + 32'h00000001, wide);
                if (roll) begin
                    st_nxt.buf_a = ccm_fit(compare_a_i, 1'b0);
                    st_nxt.buf_b = ccm_fit(compare_b_i, 1'b0);
                end
                // Single-edge modes use only the first value, so a second match stays silent
                if (match_a || (match_b && uses_b)) begin
                    st_nxt.evt = 1'b1;
                end
                case (mode)
                    ccm_pkg::OC_HIGH: if (match_a) st_nxt.out = 1'b1;
                    ccm_pkg::OC_LOW: if (match_a) st_nxt.out = 1'b0;
                    ccm_pkg::OC_TOGGLE: if (match_a) st_nxt.out = ~st_r.out;
                    ccm_pkg::OC_DUAL, ccm_pkg::OC_DUAL_BUF, ccm_pkg::OC_CENTER: begin
                        // Falling match wins so a zero-width pulse stays low
                        if (match_b) begin
                            st_nxt.out = 1'b0;
                        end else if (match_a) begin
                            st_nxt.out = 1'b1;
                        end
                    end
                    ccm_pkg::OC_VARFREQ: begin
                        st_nxt.acc = ccm_fit(acc_sum[31:0], wide);
                        st_nxt.out = carry;
                        st_nxt.evt = carry;
                    end
                    default: st_nxt.out = st_r.out;
                endcase
            end
            ccm_pkg::CCM_IC: begin
                st_nxt.ic_tmr = ccm_fit(st_r.ic_tmr + 32'h00000001, wide);
                if (rise) begin
                    st_nxt.pre_cnt = st_r.pre_cnt + 4'h1;
                end
                if (cap_hit) begin
                    st_nxt.evt = 1'b1;
                    if (st_r.cap_push && !fifo_ready) begin
                        st_nxt.overflow = 1'b1;
                    end else begin
                        st_nxt.cap_push = 1'b1;
                        st_nxt.cap_data = st_r.ic_tmr & msk;
                    end
                end
            end
            default: begin
                st_nxt.oc_tmr  = ccm_pkg::CCM_TMR_RST;
                st_nxt.ic_tmr  = ccm_pkg::CCM_TMR_RST;
                st_nxt.acc     = ccm_pkg::CCM_TMR_RST;
                st_nxt.pre_cnt = 4'h0;
                st_nxt.out     = 1'b0;
            end
        endcase
        // A new loss in the clearing cycle keeps the flag set
        if (overflow_clear_i && !(cap_hit && st_r.cap_push && !fifo_ready)) begin
            st_nxt.overflow = 1'b0;
        end
    end

    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            st_r    <= '0;
            st_r.fn <= ccm_pkg::CCM_OFF;
        end else begin
            st_r <= st_nxt;
        end
    end

    // Holding register plus FIFO: a capture waits one slot while the FIFO is full
    ccm_fifo #(
        .W     (ccm_pkg::CCM_TMR_W),
        .DEPTH (FIFO_DEPTH)
    ) ccm_fifo_inst (
        .clk_i       (clk_i),
        .reset_i     (reset_i),
        .in_valid_i  (st_r.cap_push),
        .in_ready_o  (fifo_ready),
        .in_data_i   (st_r.cap_data),
        .out_valid_o (cap_valid_o),
        .out_ready_i (cap_ready_i),
        .out_data_o  (cap_data_o)
    );

    assign compare_out_o         = st_r.out;
    assign compare_event_o       = st_r.evt;
    assign overflow_o            = st_r.overflow;
    assign channel_timer_value_o = st_r.tmr_view;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (reset_i);

    oc_high_a: assert property (match_a && mode == ccm_pkg::OC_HIGH |=> compare_out_o && compare_event_o)
        else $error("high-on-match did not drive output high");
    oc_low_a: assert property (match_a && mode == ccm_pkg::OC_LOW |=> !compare_out_o && compare_event_o)
        else $error("low-on-match did not drive output low");
    oc_toggle_a: assert property (match_a && mode == ccm_pkg::OC_TOGGLE && $stable(mode)
        |=> compare_out_o != $past(compare_out_o))
        else $error("toggle-on-match did not invert output");
    dual_fall_a: assert property (match_b && oc_legal && mode == ccm_pkg::OC_DUAL |=> !compare_out_o)
        else $error("dual edge did not fall on second match");
    reserved_idle_a: assert property (st_r.fn == ccm_pkg::CCM_OC && !oc_legal |=> $stable(compare_out_o))
        else $error("reserved mode changed the output");
    cap_rise_a: assert property (st_r.fn == ccm_pkg::CCM_IC && mode == ccm_pkg::IC_RISE && rise
        && !st_r.cap_push
        |=> st_r.cap_push && st_r.cap_data == ($past(st_r.ic_tmr) & $past(msk)))
        else $error("rising edge did not capture the timer");
    cap_fall_a: assert property (mode == ccm_pkg::IC_FALL && rise && $stable(mode) |-> !cap_hit)
        else $error("falling mode captured on a rising edge");
    tmr_count_a: assert property (st_r.fn == ccm_pkg::CCM_IC && st_nxt.fn == ccm_pkg::CCM_IC
        && $stable(wide)
        |=> st_r.ic_tmr == (($past(st_r.ic_tmr) + 32'h00000001) & $past(msk)))
        else $error("capture timer did not count up");
    tmr_view_a: assert property (##1 channel_timer_value_o == $past(st_r.ic_tmr))
        else $error("timer view is not one stage behind");
    ovf_sticky_a: assert property (overflow_o && !overflow_clear_i |=> overflow_o)
        else $error("overflow flag dropped without clear");
    ovf_set_a: assert property (cap_hit && st_r.cap_push && !fifo_ready |=> overflow_o)
        else $error("lost capture did not set overflow");

    // Compare side: events only where the mode uses the matching value
    oc_event_a: assert property (match_a && mode != ccm_pkg::OC_VARFREQ |=> compare_event_o)
        else $error("first-value match raised no event");
    oc_quiet_a: assert property (st_r.fn == ccm_pkg::CCM_OC && mode != ccm_pkg::OC_VARFREQ
        && !match_a && !(match_b && uses_b) |=> !compare_event_o)
        else $error("event raised without a match");
    dual_rise_a: assert property (match_a && !match_b && mode == ccm_pkg::OC_DUAL_BUF |=> compare_out_o)
        else $error("buffered dual edge did not rise on first match");
    buf_hold_a: assert property (st_r.fn == ccm_pkg::CCM_OC && !roll
        |=> $stable(st_r.buf_a) && $stable(st_r.buf_b))
        else $error("buffered values changed inside a period");
    buf_load_a: assert property (st_r.fn == ccm_pkg::CCM_OC && roll
        |=> st_r.buf_a == ($past(compare_a_i) & ccm_pkg::CCM_NARROW_MSK)
        && st_r.buf_b == ($past(compare_b_i) & ccm_pkg::CCM_NARROW_MSK))
        else $error("buffered values not loaded at rollover");
    center_rise_a: assert property (match_a && !match_b && mode == ccm_pkg::OC_CENTER |=> compare_out_o)
        else $error("center pulse did not rise at its first edge");
    center_fall_a: assert property (match_b && mode == ccm_pkg::OC_CENTER |=> !compare_out_o)
        else $error("center pulse did not fall at its second edge");
    vf_pulse_a: assert property (st_r.fn == ccm_pkg::CCM_OC && mode == ccm_pkg::OC_VARFREQ
        |=> compare_out_o == $past(carry) && compare_event_o == $past(carry))
        else $error("variable-frequency pulse does not follow the carry");

    // Capture side: both sources, prescaler, narrow data and the cleared start
    trig_cap_a: assert property (st_r.fn == ccm_pkg::CCM_IC && trig_select_i && mode == ccm_pkg::IC_RISE
        && trig_i && !st_r.trig_prev |-> cap_hit)
        else $error("trigger rise was not captured");
    pin_count_a: assert property (st_r.fn == ccm_pkg::CCM_IC && !trig_select_i
        && st_r.pin_sync[1] && !st_r.pin_prev |=> st_r.pre_cnt == $past(st_r.pre_cnt) + 4'h1)
        else $error("synchronised pin rise was not seen");
    pre_count_a: assert property (st_r.fn == ccm_pkg::CCM_IC && trig_select_i && rise
        |=> st_r.pre_cnt == $past(st_r.pre_cnt) + 4'h1)
        else $error("prescaler missed a trigger rise");
    rise16_skip_a: assert property (st_r.fn == ccm_pkg::CCM_IC && mode == ccm_pkg::IC_RISE16
        && st_r.pre_cnt != ccm_pkg::CCM_PRE_16TH |-> !cap_hit)
        else $error("sixteenth-rise mode captured early");
    pre_zero_a: assert property (st_r.fn == ccm_pkg::CCM_OFF |=> st_r.pre_cnt == 4'h0)
        else $error("prescaler not cleared while off");
    cap_event_a: assert property (cap_hit |=> compare_event_o)
        else $error("capture raised no event");
    fifo_push_a: assert property (st_r.cap_push && fifo_ready |=> cap_valid_o)
        else $error("pushed capture not visible at the output");
    cap_narrow_a: assert property (cap_hit && !wide && !(st_r.cap_push && !fifo_ready)
        |=> st_r.cap_data[31:16] == 16'h0000)
        else $error("narrow capture kept upper timer bits");
    cap_both_a: assert property (st_r.fn == ccm_pkg::CCM_IC && mode == ccm_pkg::IC_BOTH
        && (rise || fall) |-> cap_hit)
        else $error("rise/fall mode missed an edge");
    tmr_zero_a: assert property (st_r.fn == ccm_pkg::CCM_OFF
        |=> st_r.ic_tmr == ccm_pkg::CCM_TMR_RST && st_r.oc_tmr == ccm_pkg::CCM_TMR_RST)
        else $error("timers not cleared while off");
endmodule

// ==== core/ccm_pkg.sv ====
// Package of the capture/compare channel: mode codes, widths, counts and the state carrier.
// Assumes a single 125 MHz clock domain and control inputs held steady by software.
package ccm_pkg;

    localparam int          CCM_TMR_W      = 32;
    localparam int          CCM_NARROW_W   = 16;
    localparam int          CCM_FIFO_DEPTH = 4;
    localparam logic [31:0] CCM_NARROW_MSK = 32'h0000FFFF;
    localparam logic [31:0] CCM_WIDE_MSK   = 32'hFFFFFFFF;
    localparam logic [31:0] CCM_TMR_RST    = 32'h00000000;
    localparam int          CCM_SEL_BIT    = 4;
    localparam int          CCM_WIDE_BIT   = 5;
    localparam int          CCM_MODE_MSB   = 3;
    localparam logic [3:0]  CCM_PRE_4TH    = 4'h3;
    localparam logic [3:0]  CCM_PRE_16TH   = 4'hF;

    localparam logic [3:0]  OC_HIGH        = 4'h1;
    localparam logic [3:0]  OC_LOW         = 4'h2;
    localparam logic [3:0]  OC_TOGGLE      = 4'h3;
    localparam logic [3:0]  OC_DUAL        = 4'h4;
    localparam logic [3:0]  OC_DUAL_BUF    = 4'h5;
    localparam logic [3:0]  OC_CENTER      = 4'h6;
    localparam logic [3:0]  OC_VARFREQ     = 4'h7;

    localparam logic [3:0]  IC_EDGE        = 4'h0;
    localparam logic [3:0]  IC_RISE        = 4'h1;
    localparam logic [3:0]  IC_FALL        = 4'h2;
    localparam logic [3:0]  IC_BOTH        = 4'h3;
    localparam logic [3:0]  IC_RISE4       = 4'h4;
    localparam logic [3:0]  IC_RISE16      = 4'h5;

    typedef enum logic [2:0] {
        CCM_OFF = 3'b001,
        CCM_OC  = 3'b010,
        CCM_IC  = 3'b100
    } ccm_fn_t;

    // Field order matches the low control word: wide at bit 5, select at bit 4
    typedef struct packed {
        logic       wide_count_select;
        logic       capture_function_select;
        logic [3:0] mode;
    } ccm_ctl_t;

    typedef struct packed {
        ccm_fn_t     fn;
        logic [31:0] oc_tmr;
        logic [31:0] ic_tmr;
        logic [31:0] tmr_view;
        logic [31:0] buf_a;
        logic [31:0] buf_b;
        logic [31:0] acc;
        logic        out;
        logic        evt;
        logic [1:0]  pin_sync;
        logic        pin_prev;
        logic        trig_prev;
        logic [3:0]  pre_cnt;
        logic [31:0] cap_data;
        logic        cap_push;
        logic        overflow;
    } ccm_state_t;

endpackage

// ==== core/ccm_fifo.sv ====
// Capture FIFO: flip-flop storage addressed by index, valid/ready on both sides.
// Assumes push and pop come from logic on the same clock.
module ccm_fifo #(
    parameter int W     = 32,
    parameter int DEPTH = 4
) (
    input  wire logic         clk_i,
    input  wire logic         reset_i,
    input  wire logic         in_valid_i,
    output logic              in_ready_o,
    input  wire logic [W-1:0] in_data_i,
    output logic              out_valid_o,
    input  wire logic         out_ready_i,
    output logic [W-1:0]      out_data_o
);
    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][W-1:0] mem;
        logic [AW-1:0]           wr;
        logic [AW-1:0]           rd;
        logic [AW:0]             cnt;
    } ccm_fifo_st_t;

    ccm_fifo_st_t st_r;
    ccm_fifo_st_t st_nxt;
    logic         push;
    logic         pop;

    function automatic logic [AW-1:0] ccm_inc(input logic [AW-1:0] p);
        ccm_inc = (p == AW'(DEPTH - 1)) ? '0 : p + AW'(1);
    endfunction

    assign in_ready_o  = (st_r.cnt != (AW+1)'(DEPTH));
    assign out_valid_o = (st_r.cnt != '0);
    assign out_data_o  = st_r.mem[st_r.rd];
    assign push        = in_valid_i & in_ready_o;
    assign pop         = out_valid_o & out_ready_i;

    always_comb begin
        st_nxt = st_r;
        if (push) begin
            st_nxt.mem[st_r.wr] = in_data_i;
            st_nxt.wr           = ccm_inc(st_r.wr);
        end
        if (pop) begin
            st_nxt.rd = ccm_inc(st_r.rd);
        end
        st_nxt.cnt = st_r.cnt + (AW+1)'(push) - (AW+1)'(pop);
    end

    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end
endmodule

// ==== dv/ccm_pin_model.sv ====
// Model of the external signal that the capture channel measures.
// Assumes the pin is asynchronous to the bench clock and idles low.
module ccm_pin_model;
    timeunit 1ns;
    timeprecision 1ps;
    logic pin_o = 1'b0;

    // Pulses of 40 ns high and 40 ns low, slow enough for the two-stage synchroniser
    task automatic pulses(input int n);
        repeat (n) begin
            #40 pin_o = 1'b1;
            #40 pin_o = 1'b0;
        end
    endtask
endmodule

// ==== dv/tb_top.sv ====
// Self-checking bench of the capture/compare channel.
// Assumes a 125 MHz clock and inputs driven on the falling edge.
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic              clk_i, reset_i, enable_i, trig_i, trig_select_i, overflow_clear_i, cap_ready_i;
    ccm_pkg::ccm_ctl_t ctl;
    logic [31:0]       cmp_a, cmp_b, period, cap_data_o, tmr_view, caps[$];
    logic              cap_valid_o, compare_out_o, compare_event_o, overflow_o;
    int                fail_count, checks_done, n, ev, hi;
    ccm_pin_model      pin_inst();
    ccm_top ccm_top_inst (.clk_i(clk_i), .reset_i(reset_i), .enable_i(enable_i), .channel_control_low_i(ctl),
        .compare_a_i(cmp_a), .compare_b_i(cmp_b), .period_i(period), .capture_pin_i(pin_inst.pin_o),
        .trig_i(trig_i), .trig_select_i(trig_select_i), .overflow_clear_i(overflow_clear_i),
        .cap_ready_i(cap_ready_i), .cap_valid_o(cap_valid_o), .cap_data_o(cap_data_o),
        .compare_out_o(compare_out_o), .compare_event_o(compare_event_o), .overflow_o(overflow_o),
        .channel_timer_value_o(tmr_view));

    initial begin
        clk_i = 1'b0;
        forever #4 clk_i = ~clk_i;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            fail_count++;
            $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic test_done();
        $display("checks=%0d mismatches=%0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask

    // Disabling first clears timers and prescaler, so each scenario starts from count zero;
    // one cycle after enabling lets the edge detector see the idle level before any stimulus
    task automatic setup(input logic sel, input logic wide, input logic [3:0] m);
        @(negedge clk_i);
        enable_i = 1'b0;
        ctl = '{capture_function_select: sel, wide_count_select: wide, mode: m};
        @(negedge clk_i);
        enable_i = 1'b1;
        @(negedge clk_i);
    endtask

    task automatic trig_pulse();
        trig_i = 1'b1;
        repeat (4) @(negedge clk_i);
        trig_i = 1'b0;
        repeat (4) @(negedge clk_i);
    endtask

    // An entry seen valid at a falling edge leaves at the next rising edge, so sample before each wait
    task automatic drain(output int cnt);
        caps = {};
        cap_ready_i = 1'b1;
        repeat (12) begin
            if (cap_valid_o === 1'b1) caps.push_back(cap_data_o);
            @(negedge clk_i);
        end
        cap_ready_i = 1'b0;
        cnt = caps.size();
    endtask

    // One row per mode and width: the 100-cycle window spans two 50-cycle periods so the phase does not matter
    task automatic oc_modes();
        logic [3:0]  m[11] = '{4'h1, 4'h2, 4'h3, 4'h1, 4'h4, 4'h5, 4'h6, 4'h7, 4'h7, 4'h4, 4'h0};
        logic        w[11] = '{1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0};
        logic [31:0] a[11] = '{32'hFFFF000A, 32'hFFFF000A, 32'hFFFF000A, 32'hFFFF000A, 32'h0000000A,
                               32'h0000000A, 32'h00000019, 32'h00004000, 32'h40000000, 32'h0000000A, 32'h0000000A};
        int          xe[11] = '{2, 2, 2, 0, 4, 4, 4, 25, 25, 0, 0};
        int          xh[11] = '{100, 0, 50, 0, 40, 40, 20, 25, 25, 0, 0};
        period = 32'h00000031;
        for (int i = 0; i < 11; i++) begin
            cmp_a = a[i];
            cmp_b = (m[i] == 4'h6) ? 32'h0000000A : 32'h0000001E;
            setup(1'b0, w[i], m[i]);
            repeat (60) @(negedge clk_i);
            ev = 0;
            hi = 0;
            repeat (100) begin
                @(negedge clk_i);
                ev += (compare_event_o === 1'b1);
                hi += (compare_out_o === 1'b1);
            end
            if (xe[i] >= 0) check(32'(ev), 32'(xe[i]));
            check(32'(hi), 32'(xh[i]));
        end
    endtask

    task automatic cap_edges();
        int xc[4] = '{2, 1, 1, 2};
        trig_select_i = 1'b1;
        for (int i = 0; i < 4; i++) begin
            setup(1'b1, 1'b0, 4'(i));
            trig_pulse();
            drain(n);
            check(32'(n), 32'(xc[i]));
        end
    endtask

    task automatic cap_delta();
        logic [31:0] t0;
        setup(1'b1, 1'b1, 4'h1);
        repeat (3) @(negedge clk_i);
        t0 = tmr_view;
        repeat (5) @(negedge clk_i);
        check(tmr_view - t0, 32'h00000005);
        trig_i = 1'b1;
        repeat (37) @(negedge clk_i);
        trig_i = 1'b0;
        repeat (4) @(negedge clk_i);
        trig_pulse();
        drain(n);
        check(32'(n), 32'h00000002);
        if (n == 2) check(caps[1] - caps[0], 32'h00000029);
    endtask

    task automatic cap_prescale();
        trig_select_i = 1'b0;
        setup(1'b1, 1'b0, 4'h4);
        pin_inst.pulses(8);
        repeat (6) @(negedge clk_i);
        drain(n);
        check(32'(n), 32'h00000002);
        setup(1'b1, 1'b1, 4'h5);
        pin_inst.pulses(32);
        repeat (6) @(negedge clk_i);
        drain(n);
        check(32'(n), 32'h00000002);
    endtask

    // Holding slot plus a full FIFO keep five values; the sixth is lost
    task automatic cap_overflow();
        trig_select_i = 1'b1;
        setup(1'b1, 1'b0, 4'h1);
        repeat (6) trig_pulse();
        check(32'(overflow_o), 32'h00000001);
        drain(n);
        check(32'(n), 32'h00000005);
        overflow_clear_i = 1'b1;
        @(negedge clk_i);
        overflow_clear_i = 1'b0;
        @(negedge clk_i);
        check(32'(overflow_o), 32'h00000000);
    endtask

    initial begin
        fail_count = 0;
        checks_done = 0;
        reset_i = 1'b1;
        enable_i = 1'b0;
        ctl = '{1'b0, 1'b0, 4'h0};
        cmp_a = 32'h00000000;
        cmp_b = 32'h00000000;
        period = 32'h00000031;
        trig_i = 1'b0;
        trig_select_i = 1'b0;
        overflow_clear_i = 1'b0;
        cap_ready_i = 1'b0;
        repeat (4) @(negedge clk_i);
        reset_i = 1'b0;
        check({cap_valid_o, compare_out_o, overflow_o}, 32'h00000000);
        oc_modes();
        cap_edges();
        cap_delta();
        cap_prescale();
        cap_overflow();
        test_done();
    end

    // Scenarios need roughly 2500 cycles; the limit leaves wide margin
    initial begin
        #200000;
        fail_count++;
        test_done();
    end
endmodule
